// file: verilog/phy_next_page_mmd_loopback_regs.sv
// one phy port: next page words, indirect mmd access and remote loopback
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "phy_np_cfg.svh"
module phy_next_page_mmd_loopback_regs
  import phy_np_pkg::*;
#(
  parameter int MMD_ADDR_BITS = 4,
  parameter int LINE_W = 4
)(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // auto-negotiation engine
  output logic [15:0] tx_next_page_word,
  input wire logic prev_tx_toggle,
  input wire logic page_rx_strobe,
  input wire logic [15:0] page_rx_word,
  // line side of the port
  input wire logic line_rx_valid,
  input wire logic [LINE_W-1:0] line_rx_data,
  output logic line_tx_valid,
  output logic [LINE_W-1:0] line_tx_data,
  // switch fabric side of the port
  input wire logic fabric_tx_valid,
  input wire logic [LINE_W-1:0] fabric_tx_data,
  output logic fabric_tx_ready,
  output logic fabric_rx_valid,
  output logic [LINE_W-1:0] fabric_rx_data
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  bus_state_t bus_state;
  logic [7:0] dp_idx;
  logic np_more;
  logic np_msg_page;
  logic np_ack2;
  logic [10:0] np_msg;
  logic np_toggle;
  logic [15:0] partner_word;
  logic [15:0] pending_word;
  logic page_rx_latch;
  mmd_op_t mmd_op;
  logic [8:0] mmd_rsv;
  logic [4:0] mmd_dev;
  logic [15:0] mmd_reg_addr;
  logic [15:0] mmd_mem [0:(32<<MMD_ADDR_BITS)-1];
  logic [6:0] loop_rsv_hi;
  logic [5:0] loop_rsv_lo;
  logic loop_rc;
  logic loop_en;
  logic wr_now;
  logic rd_now;
  logic [15:0] rd_value;
  logic [15:0] wdata;

  // word index of an aligned byte address
  function automatic logic [7:0] word_index(input logic [31:0] a);
    word_index = a[9:2];
  endfunction : word_index

  // memory slot for the selected device and register address
  function automatic logic [MMD_ADDR_BITS+4:0] mmd_slot(input logic [4:0] dev,
                                                        input logic [15:0] ra);
    mmd_slot = {dev, ra[MMD_ADDR_BITS-1:0]};
  endfunction : mmd_slot

  assign wdata = hwdata[15:0];
  assign wr_now = (bus_state == BUS_WRITE);
  assign rd_now = (bus_state == BUS_READ);
  assign hresp = 1'b0;
  // reads hold one wait cycle so hrdata comes from a flop
  assign hreadyout = (bus_state != BUS_READ);

  // ----------------------------------------
  // ahb-lite bus phases
  // ----------------------------------------

  // address phase taken when selected, active and the bus is ready
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state <= BUS_IDLE;
      dp_idx <= 8'h00;
    end
    else if (bus_state == BUS_READ)
      bus_state <= BUS_RDATA;
    else if (hready && hsel && htrans[1])
    begin
      bus_state <= hwrite ? BUS_WRITE : BUS_READ;
      dp_idx <= word_index(haddr);
    end
    else
      bus_state <= BUS_IDLE;
  end

  // read multiplexer; unmapped words read zero
  always_comb
  begin
    rd_value = 16'h0000;
    unique case (dp_idx)
      `IDX_AN_EXPANSION: rd_value[`PAGE_RX_BIT] = page_rx_latch;
      `IDX_LOCAL_NP: rd_value = {np_more, 1'b0, np_msg_page, np_ack2, np_toggle, np_msg};
      `IDX_PARTNER_NP: rd_value = partner_word; // [R05] [R06] [R07] [R08]
      `IDX_MMD_SETUP: rd_value = {mmd_op, mmd_rsv, mmd_dev};
      `IDX_MMD_DATA:
        rd_value = (mmd_op == MMD_OP_ADDR) ? mmd_reg_addr // [R11]
                 : mmd_mem[mmd_slot(mmd_dev, mmd_reg_addr)]; // [R12]
      `IDX_LOOPBACK: rd_value = {loop_rsv_hi, loop_en, loop_rsv_lo, loop_rc, 1'b0};
      default: rd_value = 16'h0000;
    endcase
  end

  // read data register, upper half reads zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_now)
      hrdata <= {16'h0000, rd_value};
  end

  // ----------------------------------------
  // local next page word
  // ----------------------------------------

  // writable fields of the transmitted next page
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      np_more <= 1'b0; // [R01]
      np_msg_page <= 1'b1; // [R02]
      np_ack2 <= 1'b0;
      np_msg <= `LOCAL_NP_MSG_RST; // [R02]
    end
    else if (wr_now && dp_idx == `IDX_LOCAL_NP)
    begin
      np_more <= wdata[`NP_MORE_BIT]; // [R01]
      np_msg_page <= wdata[`NP_MSG_PAGE_BIT]; // [R02]
      np_ack2 <= wdata[`NP_ACK2_BIT]; // [R03]
      np_msg <= wdata[10:0]; // [R02]
    end
  end

  // toggle follows the previously transmitted word, not software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      np_toggle <= 1'b0; // [R04]
    else
      np_toggle <= prev_tx_toggle; // [R04]
  end

  // word handed to the negotiation engine; bit 14 stays zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_next_page_word <= {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, `LOCAL_NP_MSG_RST};
    else
      tx_next_page_word <= {np_more, 1'b0, np_msg_page, np_ack2, np_toggle, np_msg}; // [R03]
  end

  // ----------------------------------------
  // partner next page and page-received latch
  // ----------------------------------------

  // latch sets on a new page; a read clears it, but a new page wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      page_rx_latch <= 1'b0;
    else if (page_rx_strobe)
      page_rx_latch <= 1'b1; // [R16]
    else if (rd_now && dp_idx == `IDX_AN_EXPANSION)
      page_rx_latch <= 1'b0; // [R16]
  end

  // newest received page waits here until the latch is read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pending_word <= 16'h0000;
    else if (page_rx_strobe)
      pending_word <= page_rx_word;
  end

  // partner word is read-only and only moves on the latch read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      partner_word <= 16'h0000;
    else if (rd_now && dp_idx == `IDX_AN_EXPANSION)
      partner_word <= page_rx_strobe ? page_rx_word : pending_word; // [R16]
  end

  // ----------------------------------------
  // indirect mmd access
  // ----------------------------------------

  // setup register: operation, reserved and device address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mmd_op <= MMD_OP_ADDR; // [R10]
      mmd_rsv <= `MMD_SETUP_RSV_RST;
      mmd_dev <= 5'h00; // [R10]
    end
    else if (wr_now && dp_idx == `IDX_MMD_SETUP)
    begin
      mmd_op <= mmd_op_t'(wdata[15:14]); // [R09]
      mmd_rsv <= wdata[13:5];
      mmd_dev <= wdata[4:0]; // [R10]
    end
  end

  // stored register address: loaded in address mode, stepped after each access in mode 10 and after each write in mode 11
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mmd_reg_addr <= `MMD_DATA_RST;
    else if (dp_idx == `IDX_MMD_DATA && (wr_now || rd_now))
    begin
      unique case (mmd_op)
        MMD_OP_ADDR:
          if (wr_now)
            mmd_reg_addr <= wdata; // [R11] [R18]
        MMD_OP_DATA: mmd_reg_addr <= mmd_reg_addr; // [R09]
        MMD_OP_INC_RW: mmd_reg_addr <= mmd_reg_addr + 16'h0001; // [R09] [R18]
        MMD_OP_INC_WR:
          if (wr_now)
            mmd_reg_addr <= mmd_reg_addr + 16'h0001; // [R09] [R18]
      endcase
    end
  end

  // mmd register contents, written through the data register
  always_ff @(posedge hclk)
  begin
    if (wr_now && dp_idx == `IDX_MMD_DATA && mmd_op != MMD_OP_ADDR)
      mmd_mem[mmd_slot(mmd_dev, mmd_reg_addr)] <= wdata; // [R12]
  end

  // ----------------------------------------
  // remote loopback
  // ----------------------------------------

  // loopback register; reserved low field resets to 111101
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      loop_rsv_hi <= `LOOP_RSV_HI_RST; // [R15]
      loop_en <= 1'b0; // [R13]
      loop_rsv_lo <= `LOOP_RSV_LO_RST; // [R15]
      loop_rc <= 1'b0;
    end
    else if (wr_now && dp_idx == `IDX_LOOPBACK)
    begin
      loop_rsv_hi <= wdata[15:9];
      loop_en <= wdata[`LOOP_EN_BIT]; // [R13]
      loop_rsv_lo <= wdata[7:2];
      loop_rc <= wdata[`LOOP_RC_BIT];
    end
    else if (rd_now && dp_idx == `IDX_LOOPBACK)
      loop_rc <= 1'b0; // bit 1 clears on read
  end

  // fabric is held off entirely while looping
  assign fabric_tx_ready = !loop_en; // [R14]

  // line transmit: received data in loopback, fabric data otherwise
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line_tx_valid <= 1'b0;
      line_tx_data <= '0;
    end
    else if (loop_en)
    begin
      line_tx_valid <= line_rx_valid; // [R13]
      line_tx_data <= line_rx_data; // [R13]
    end
    else
    begin
      line_tx_valid <= fabric_tx_valid;
      line_tx_data <= fabric_tx_data;
    end
  end

  // fabric receive: nothing passes up while looping
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fabric_rx_valid <= 1'b0;
      fabric_rx_data <= '0;
    end
    else
    begin
      fabric_rx_valid <= line_rx_valid && !loop_en; // [R14]
      fabric_rx_data <= loop_en ? '0 : line_rx_data; // [R14]
    end
  end

endmodule : phy_next_page_mmd_loopback_regs

// file: verilog/phy_np_cfg.svh
// offsets, field positions and reset values of the port register set
// Overview of operation
// R01 - local word bit 15 says more next pages follow; resets to zero
// R02 - local bit 13 selects message page, resets one; message field resets 0x001
// R03 - local bit 12 tells partner whether the device will comply with message
// R04 - local bit 11 is read-only, resets zero, shows previous transmitted toggle value
// R05 - partner bit 11 reads one when previous transmitted word was zero
// R06 - partner bit 14 is read-only acknowledge of successful link word receipt
// R07 - partner bit 12 is read-only: partner able to act on the message
// R08 - partner bits 10 to 0 hold the partner message field, read-only
// R09 - mmd operation field: 00 address, 01 data, 10 inc both, 11 inc on write
// R10 - mmd device address field is writable, five bits, resets zero with all others
// R11 - in address mode the data register loads and returns the mmd register address
// R12 - in data modes the data register moves the selected mmd register contents
// R13 - remote loopback bit 8 sends line receive data back out the same port
// R14 - looped traffic never reaches nor comes from the switch fabric
// R15 - loopback register bits 7 to 2 reset to 111101, other reserved bits zero
// R16 - page-received latch sets on new page; read clears it and updates partner word
// R17 - software writes reserved fields back with reset values and paces next pages
// R18 - post-increment modes advance stored mmd address; data mode never alters it
`ifndef PHY_NP_CFG_SVH
`define PHY_NP_CFG_SVH
// register indices; byte address is four times the index
`define IDX_AN_EXPANSION 8'h06
`define IDX_LOCAL_NP 8'h07
`define IDX_PARTNER_NP 8'h08
`define IDX_MMD_SETUP 8'h0d
`define IDX_MMD_DATA 8'h0e
`define IDX_LOOPBACK 8'h11
// field positions
`define NP_MORE_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_PAGE_BIT 13
`define NP_ACK2_BIT 12
`define NP_TOGGLE_BIT 11
`define PAGE_RX_BIT 1
`define LOOP_EN_BIT 8
`define LOOP_RC_BIT 1
// reset values
`define LOCAL_NP_MSG_RST 11'h001
`define LOOP_RSV_HI_RST 7'h00
`define LOOP_RSV_LO_RST 6'h3d
`define MMD_SETUP_RSV_RST 9'h000
`define MMD_DATA_RST 16'h0000
`endif

// file: verilog/phy_np_pkg.sv
// types shared by the port register set
package phy_np_pkg;
  typedef enum logic [1:0] {
    MMD_OP_ADDR = 2'b00,
    MMD_OP_DATA = 2'b01,
    MMD_OP_INC_RW = 2'b10,
    MMD_OP_INC_WR = 2'b11
  } mmd_op_t;
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_READ = 4'b0100,
    BUS_RDATA = 4'b1000
  } bus_state_t;
endpackage : phy_np_pkg

// file: tb/phy_np_assertions.sv
// concurrent checks on the pins of one port register set
`timescale 1ns/1ps
module phy_np_checker #(
  parameter int LINE_W = 4
)(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // page words
  input wire logic [15:0] tx_next_page_word,
  input wire logic prev_tx_toggle,
  // line and fabric
  input wire logic line_rx_valid,
  input wire logic [LINE_W-1:0] line_rx_data,
  input wire logic line_tx_valid,
  input wire logic [LINE_W-1:0] line_tx_data,
  input wire logic fabric_tx_ready,
  input wire logic fabric_rx_valid
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [1:0] up_cnt;
  wire logic take = hsel && hready && htrans[1];
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // cycles since reset release, saturating
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  end
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_RD_WAIT: assert property (take && !hwrite |=> s_rd_wait)
    else $error("read data phase not one wait state");
  AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  AST_RESP_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_RD_UPPER: assert property ($rose(hreadyout) |-> hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_NP_RESET: assert property ($rose(hresetn) |-> tx_next_page_word == 16'h2001)
    else $error("next page word reset value wrong");
  AST_NP_TOGGLE: assert property (up_cnt == 2'h3 |->
    tx_next_page_word[11] == $past(prev_tx_toggle, 2))
    else $error("toggle bit does not follow engine");
  AST_LOOP_DATA: assert property (!fabric_tx_ready && line_rx_valid |=>
    line_tx_valid && line_tx_data == $past(line_rx_data))
    else $error("looped data not returned");
  AST_LOOP_ISOLATE: assert property (!fabric_tx_ready && !$past(fabric_tx_ready)
    |-> !fabric_rx_valid)
    else $error("looped traffic reached fabric");
endmodule : phy_np_checker

bind phy_next_page_mmd_loopback_regs phy_np_checker #(.LINE_W(LINE_W)) chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .tx_next_page_word(tx_next_page_word), .prev_tx_toggle(prev_tx_toggle),
  .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data),
  .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
  .fabric_tx_ready(fabric_tx_ready), .fabric_rx_valid(fabric_rx_valid));

// file: tb/link_partner_model.sv
// far end of the twisted pair: line symbols and received pages
`timescale 1ns/1ps
module link_partner_model #(
  parameter int LINE_W = 4
)(
  // clock
  input wire logic hclk,
  // toward the port
  output logic rx_valid,
  output logic [LINE_W-1:0] rx_data,
  output logic page_strobe,
  output logic [15:0] page_word
);
  initial
  begin
    rx_valid = 1'b0;
    rx_data = '0;
    page_strobe = 1'b0;
    page_word = 16'h0000;
  end
  // one-cycle page pulse; word is scrambled once the pulse ends
  task send_page(input logic [15:0] w);
    @(posedge hclk);
    page_strobe <= 1'b1;
    page_word <= w;
    @(posedge hclk);
    page_strobe <= 1'b0;
    page_word <= ~w;
  endtask : send_page
  // one symbol time; idle symbols carry the inverse of the last data
  task send_sym(input logic [LINE_W-1:0] d, input logic v);
    @(posedge hclk);
    rx_valid <= v;
    rx_data <= v ? d : ~rx_data;
  endtask : send_sym
endmodule : link_partner_model

// file: tb/phy_next_page_mmd_loopback_regs_tb_top.sv
// self-checking bench for one port register set
`timescale 1ns/1ps
`include "phy_np_cfg.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module phy_next_page_mmd_loopback_regs_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, prev_tx_toggle, fabric_tx_valid;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, line_rx_valid, page_rx_strobe;
  logic line_tx_valid, fabric_tx_ready, fabric_rx_valid;
  logic [15:0] tx_next_page_word, page_rx_word, w, a, v0, v1;
  logic [3:0] line_rx_data, line_tx_data, fabric_tx_data, fabric_rx_data, d;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  always #12.5 hclk = ~hclk;
  phy_next_page_mmd_loopback_regs #(.MMD_ADDR_BITS(4), .LINE_W(4)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_next_page_word(tx_next_page_word), .prev_tx_toggle(prev_tx_toggle),
    .page_rx_strobe(page_rx_strobe), .page_rx_word(page_rx_word),
    .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data),
    .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
    .fabric_tx_valid(fabric_tx_valid), .fabric_tx_data(fabric_tx_data),
    .fabric_tx_ready(fabric_tx_ready), .fabric_rx_valid(fabric_rx_valid),
    .fabric_rx_data(fabric_rx_data));
  link_partner_model #(.LINE_W(4)) partner (.hclk(hclk), .rx_valid(line_rx_valid),
    .rx_data(line_rx_data), .page_strobe(page_rx_strobe), .page_word(page_rx_word));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // one single transfer; hrdata is taken at the data phase's ready edge
  task bus_xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                output logic [15:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {16'h0000, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata[15:0];
  endtask : bus_xfer
  task bus_wr(input logic [7:0] idx, input logic [15:0] wd);
    logic [15:0] dummy;
    bus_xfer(1'b1, idx, wd, dummy);
  endtask : bus_wr
  task rd_chk(input logic [7:0] idx, input logic [15:0] ex, input string nm);
    logic [15:0] rd;
    bus_xfer(1'b0, idx, 16'h0000, rd);
    `CHK(nm, ex, rd)
  endtask : rd_chk
  // watchdog on a hung handshake
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    haddr = 32'h0; hwdata = 32'h0; prev_tx_toggle = 1'b0;
    fabric_tx_valid = 1'b0; fabric_tx_data = 4'h0;
    void'($urandom(27280));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(`IDX_LOCAL_NP, 16'h2001, "local np reset");
    rd_chk(`IDX_MMD_SETUP, 16'h0000, "mmd setup reset");
    rd_chk(`IDX_MMD_DATA, 16'h0000, "mmd data reset");
    rd_chk(`IDX_LOOPBACK, 16'h00f4, "loopback reset");
    rd_chk(8'h3f, 16'h0000, "unmapped");
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      w = (i == 0) ? 16'hffff : 16'($urandom);
      prev_tx_toggle <= w[0];
      bus_wr(`IDX_LOCAL_NP, w);
      rd_chk(`IDX_LOCAL_NP, (w & 16'hb7ff) | {4'h0, w[0], 11'h0}, "local np");
      `CHK("tx np", (w & 16'hb7ff) | {4'h0, w[0], 11'h0}, tx_next_page_word)
    end
    $display("test local page done");
    w = 16'($urandom);
    partner.send_page(w);
    rd_chk(`IDX_PARTNER_NP, 16'h0000, "partner held");
    rd_chk(`IDX_AN_EXPANSION, 16'h0002, "page received");
    rd_chk(`IDX_PARTNER_NP, w, "partner np");
    rd_chk(`IDX_AN_EXPANSION, 16'h0000, "page latch clear");
    $display("test partner page done");
    for (int m = 1; m < 4; m++)
    begin
      w = {11'h0, 5'($urandom_range(31))};
      a = 16'($urandom_range(13));
      v0 = 16'($urandom);
      v1 = 16'($urandom);
      bus_wr(`IDX_MMD_SETUP, w);
      bus_wr(`IDX_MMD_DATA, a);
      bus_wr(`IDX_MMD_SETUP, {m[1:0], w[13:0]});
      rd_chk(`IDX_MMD_SETUP, {m[1:0], w[13:0]}, "mmd setup");
      bus_wr(`IDX_MMD_DATA, v0);
      bus_wr(`IDX_MMD_DATA, v1);
      bus_wr(`IDX_MMD_SETUP, w);
      rd_chk(`IDX_MMD_DATA, (m == 1) ? a : a + 16'h2, "addr after writes");
      bus_wr(`IDX_MMD_DATA, a);
      bus_wr(`IDX_MMD_SETUP, {m[1:0], w[13:0]});
      rd_chk(`IDX_MMD_DATA, (m == 1) ? v1 : v0, "mmd read 1");
      rd_chk(`IDX_MMD_DATA, (m == 3) ? v0 : v1, "mmd read 2");
      bus_wr(`IDX_MMD_SETUP, w);
      rd_chk(`IDX_MMD_DATA, (m == 2) ? a + 16'h2 : a, "addr after reads");
    end
    $display("test mmd modes done");
    bus_wr(`IDX_LOOPBACK, 16'h01f4);
    rd_chk(`IDX_LOOPBACK, 16'h01f4, "loopback on");
    for (int i = 0; i < 8; i++)
    begin
      d = 4'($urandom);
      fabric_tx_valid <= 1'b1;
      fabric_tx_data <= ~d;
      partner.send_sym(d, 1'b1);
      repeat (2) @(posedge hclk);
      `CHK("line tx looped", d, line_tx_data)
      `CHK("line tx valid looped", 1'b1, line_tx_valid)
      `CHK("fabric rx blocked", 1'b0, fabric_rx_valid)
      `CHK("fabric tx blocked", 1'b0, fabric_tx_ready)
      partner.send_sym(4'h0, 1'b0);
    end
    bus_wr(`IDX_LOOPBACK, 16'h00f4);
    partner.send_sym(d, 1'b1);
    repeat (2) @(posedge hclk);
    `CHK("fabric rx normal", d, fabric_rx_data)
    `CHK("fabric rx valid normal", 1'b1, fabric_rx_valid)
    `CHK("line tx valid normal", 1'b1, line_tx_valid)
    `CHK("line tx normal", ~d, line_tx_data)
    $display("test loopback done");
    close_out();
  end
endmodule : phy_next_page_mmd_loopback_regs_tb_top
